/* shared/wdtc_map.svh */
// Purpose: Constants for the watchdog configuration block
// Assumes: Included by the top module
// Notes:   Byte address of a register is four times its index
//
// What this block does
// - Level 1: watchdog starts off; writing enable one turns it on freely.
// - Level 2: watchdog always on; enable bit always reads one.
// - Level 2 timeout change: unlock write, then select write; enable ignored.
// - Level 2: disable refused even after a full unlock sequence.
// - Unlock bit clears itself four clock cycles after being set.
// - Enable cleared by a zero write only while unlock bit is one.
// - Timeout select changes accepted only while unlock bit is set.
// - Level 1: enable forced to one while watchdog reset flag is set.
// - Watchdog reset sets bit 3; power-on or zero write clears it.
// - Brown-out reset sets bit 2; power-on or zero write clears it.
// - External reset sets bit 1; power-on or zero write clears it.
// - Power-on reset sets bit 0; only a zero write clears it.
// - Reset-cause bits 7 to 4 always read as zero.
// - Timeout in interrupt mode sets bit 7; vector or one-write clears.
// - Interrupt taken only with flag and global enable, plus interrupt enable or a held both-set timeout.
// - Mode table: stopped, interrupt, reset, or interrupt when both set.
// - With both set, timeout clears interrupt enable so next one resets.
// - Select 0 gives 2K cycles, doubling up to 1024K at 9.
// - Control layout: flag 7, irq enable 6, sel3 5, unlock 4, enable 3.
// - Counter runs from a 128 kHz tick divided down from the system clock.
// - Counter restarts on restart instruction, when disabled, on chip reset.
// - Fuse unprogrammed gives level 1, programmed gives level 2.
// - Watchdog reset is a one system clock pulse.
`ifndef WDTC_MAP_SVH
`define WDTC_MAP_SVH
`define WDTC_IDX_CTRL    8'h21
`define WDTC_IDX_CAUSE   8'h34
`define WDTC_B_FLAG      7
`define WDTC_B_IE        6
`define WDTC_B_TS3       5
`define WDTC_B_CU        4
`define WDTC_B_EN        3
`define WDTC_B_WDOG_RESET_FLAG      3
`define WDTC_B_BROWNOUT_RESET_FLAG      2
`define WDTC_B_PIN_RESET_FLAG     1
`define WDTC_B_POWERON_RESET_FLAG      0
`define WDTC_CAUSE_RST   4'h1
`define WDTC_CLK_HZ      100000000
`define WDTC_OSC_HZ      128000
`define WDTC_DIV         (`WDTC_CLK_HZ / `WDTC_OSC_HZ)
`define WDTC_UNLOCK_CYC  3'h4
`define WDTC_TS_BASE     21'h000800
`define WDTC_TS_MAX      4'h9
`endif

/* shared/wdtc_pkg.sv */
// Purpose: Types for the watchdog configuration block
// Assumes: Constants come from the map header
// Notes:   None
`default_nettype none
package wdtc_pkg;
  typedef struct packed {
    logic       flag;
    logic       ie;
    logic       en;
    logic [3:0] ts;
  } wdtc_ctrl_t;
  typedef struct packed {
    logic wd;
    logic bo;
    logic ext;
    logic por;
  } wdtc_cause_t;
  typedef enum logic [1:0] {
    WDTC_ST_IDLE = 2'b01,
    WDTC_ST_ACK  = 2'b10
  } wdtc_apb_st_t;
endpackage
`default_nettype wire

/* core/wdtc_top.sv */
// Purpose: Watchdog control, timed unlock and reset-cause flags
// Assumes: APB slave, one clock, oscillator tick from a divider
// Notes:   One wait state on every APB access
`include "wdtc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module wdtc_top
  import wdtc_pkg::*;
#(
  parameter int DIV_CYCLES = `WDTC_DIV
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // CPU side
  input  wire logic        wdog_restart_instr,
  input  wire logic        cpu_gie,
  input  wire logic        irq_ack,
  // Pins and detectors
  input  wire logic        safety_level_fuse,
  input  wire logic        pin_reset_req,
  input  wire logic        brownout_req,
  // Results
  output var  logic        wdog_irq,
  output var  logic        wdog_reset
);

  //////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [11:0] addr_of(input logic [7:0] idx);
    addr_of = {2'h0, idx, 2'h0};
  endfunction

  function automatic logic [20:0] limit_of(input logic [3:0] ts);
    logic [3:0] t;
    t = ts;
    if (t > `WDTC_TS_MAX) begin
      t = `WDTC_TS_MAX;
    end
    limit_of = `WDTC_TS_BASE << t;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Declarations

  wdtc_apb_st_t st_q;
  wdtc_apb_st_t st_d;
  wdtc_ctrl_t   ctrl_q;
  wdtc_cause_t  cause_q;
  logic         cu_q;
  logic [2:0]   cu_cnt_q;
  logic [15:0]  div_q;
  logic         tick_q;
  logic [20:0]  cnt_q;
  logic [1:0]   fuse_sy_q;
  logic [1:0]   ext_sy_q;
  logic [1:0]   bor_sy_q;
  logic [31:0]  prdata_q;
  logic         pready_q;
  logic         pslverr_q;
  logic         irq_q;
  logic         irq_held_q;
  logic         wrst_q;
  logic         lvl2;
  logic         ext_s;
  logic         bor_s;
  logic         sys_rst;
  logic         eff_en;
  logic         running;
  logic         timeout;
  logic         hit_ctrl;
  logic         hit_cause;
  logic         wr_go;
  logic         wr_ctrl;
  logic         wr_cause;
  logic         unlock_start;
  logic         seq_write;
  logic [7:0]   rd_ctrl;
  logic [7:0]   rd_cause;
  logic [7:0]   wd;

  //////////////////////////////////////////////////////////////////////
  // Synchronisers

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fuse_sy_q <= 2'h0;
      ext_sy_q  <= 2'h0;
      bor_sy_q  <= 2'h0;
    end else begin
      fuse_sy_q <= {fuse_sy_q[0], safety_level_fuse};
      ext_sy_q  <= {ext_sy_q[0], pin_reset_req};
      bor_sy_q  <= {bor_sy_q[0], brownout_req};
    end
  end

  assign lvl2  = fuse_sy_q[1];
  assign ext_s = ext_sy_q[1];
  assign bor_s = bor_sy_q[1];

  assign sys_rst = wrst_q | ext_s | bor_s;

  //////////////////////////////////////////////////////////////////////
  // Decode

  assign wd        = pwdata[7:0];
  assign hit_ctrl  = (paddr == addr_of(`WDTC_IDX_CTRL));
  assign hit_cause = (paddr == addr_of(`WDTC_IDX_CAUSE));
  assign wr_go     = (st_q == WDTC_ST_ACK) & psel & penable & pwrite;
  assign wr_ctrl   = wr_go & hit_ctrl;
  assign wr_cause  = wr_go & hit_cause;

  assign unlock_start = wr_ctrl & wd[`WDTC_B_CU] & wd[`WDTC_B_EN];
  assign seq_write    = wr_ctrl & cu_q & ~wd[`WDTC_B_CU];

  assign eff_en = ctrl_q.en | lvl2 | cause_q.wd;

  assign running = eff_en | ctrl_q.ie;

  assign rd_ctrl = {ctrl_q.flag, ctrl_q.ie, ctrl_q.ts[3], cu_q,
                    eff_en, ctrl_q.ts[2:0]};

  assign rd_cause = {4'h0, cause_q.wd, cause_q.bo, cause_q.ext,
                     cause_q.por};

  //////////////////////////////////////////////////////////////////////
  // APB state

  always_comb begin
    st_d = st_q;
    case (st_q)
      WDTC_ST_IDLE: begin
        if (psel & penable) begin
          st_d = WDTC_ST_ACK;
        end
      end
      WDTC_ST_ACK: begin
        st_d = WDTC_ST_IDLE;
      end
      default: begin
        st_d = WDTC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= WDTC_ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if ((st_q == WDTC_ST_IDLE) && psel && penable) begin
      pready_q  <= 1'b1;
      pslverr_q <= ~(hit_ctrl | hit_cause);
      if (pwrite) begin
        prdata_q <= 32'h0000_0000;
      end else if (hit_ctrl) begin
        prdata_q <= {24'h00_0000, rd_ctrl};
      end else if (hit_cause) begin
        prdata_q <= {24'h00_0000, rd_cause};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Unlock window

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cu_q     <= 1'b0;
      cu_cnt_q <= 3'h0;
    end else if (sys_rst) begin
      cu_q     <= 1'b0;
      cu_cnt_q <= 3'h0;
    end else if (unlock_start) begin
      cu_q     <= 1'b1;
      cu_cnt_q <= `WDTC_UNLOCK_CYC;
    end else if (seq_write) begin
      cu_q     <= 1'b0;
      cu_cnt_q <= 3'h0;
    end else if (cu_q) begin
      cu_cnt_q <= cu_cnt_q - 3'h1;
      if (cu_cnt_q == 3'h1) begin
        cu_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Enable bit

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q.en <= 1'b0;
    end else if (sys_rst) begin
      ctrl_q.en <= 1'b0;
    end else if (wr_ctrl) begin
      if (wd[`WDTC_B_EN]) begin
        ctrl_q.en <= 1'b1;
      end else if (seq_write && !lvl2 && !cause_q.wd) begin
        ctrl_q.en <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Timeout select

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q.ts <= 4'h0;
    end else if (sys_rst) begin
      ctrl_q.ts <= 4'h0;
    end else if (seq_write) begin
      ctrl_q.ts <= {wd[`WDTC_B_TS3], wd[2:0]};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Interrupt enable and flag

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q.ie <= 1'b0;
    end else if (sys_rst) begin
      ctrl_q.ie <= 1'b0;
    end else if (timeout && eff_en && ctrl_q.ie) begin
      ctrl_q.ie <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_q.ie <= wd[`WDTC_B_IE];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q.flag <= 1'b0;
    end else if (sys_rst) begin
      ctrl_q.flag <= 1'b0;
    end else if (timeout && ctrl_q.ie) begin
      ctrl_q.flag <= 1'b1;
    end else if (irq_ack) begin
      ctrl_q.flag <= 1'b0;
    end else if (wr_ctrl && wd[`WDTC_B_FLAG]) begin
      ctrl_q.flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_held_q <= 1'b0;
    end else if (timeout && eff_en && ctrl_q.ie) begin
      irq_held_q <= 1'b1;
    end else if (sys_rst || irq_ack || wr_ctrl) begin
      irq_held_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ctrl_q.flag & (ctrl_q.ie | irq_held_q) & cpu_gie;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Oscillator tick

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q == 16'(DIV_CYCLES - 1)) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Counter

  assign timeout = tick_q & running &
                   (cnt_q == (limit_of(ctrl_q.ts) - 21'h000001));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 21'h000000;
    end else if (wdog_restart_instr || !running || sys_rst || timeout) begin
      cnt_q <= 21'h000000;
    end else if (tick_q) begin
      cnt_q <= cnt_q + 21'h000001;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Watchdog reset

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrst_q <= 1'b0;
    end else begin
      wrst_q <= timeout & eff_en & ~ctrl_q.ie & ~wrst_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Reset causes

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cause_q <= `WDTC_CAUSE_RST;
    end else begin
      if (wrst_q) begin
        cause_q.wd <= 1'b1;
      end else if (wr_cause && !wd[`WDTC_B_WDOG_RESET_FLAG]) begin
        cause_q.wd <= 1'b0;
      end
      if (bor_s) begin
        cause_q.bo <= 1'b1;
      end else if (wr_cause && !wd[`WDTC_B_BROWNOUT_RESET_FLAG]) begin
        cause_q.bo <= 1'b0;
      end
      if (ext_s) begin
        cause_q.ext <= 1'b1;
      end else if (wr_cause && !wd[`WDTC_B_PIN_RESET_FLAG]) begin
        cause_q.ext <= 1'b0;
      end
      if (wr_cause && !wd[`WDTC_B_POWERON_RESET_FLAG]) begin
        cause_q.por <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign wdog_irq   = irq_q;
  assign wdog_reset = wrst_q;

endmodule
`default_nettype wire

/* verif/wdtc_properties.sv */
// Purpose: Port checker for the watchdog control block
// Assumes: Bound to wdtc_top, one clock domain
// Notes:   Register byte addresses 0x084 and 0x0D0
`timescale 1ns/1ps
`default_nettype none
module wdtc_properties (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Side signals
  input wire logic        cpu_gie,
  input wire logic        safety_level_fuse,
  input wire logic        wdog_irq,
  input wire logic        wdog_reset
);
  logic [3:0] gap_q;
  logic       rd_ctrl;
  assign rd_ctrl = pready && !pwrite && paddr == 12'h084;
  // Cycles since the last control write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      gap_q <= 4'h0;
    else if (pready && pwrite && paddr == 12'h084)
      gap_q <= 4'h0;
    else if (gap_q != 4'hF)
      gap_q <= gap_q + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_ack_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("late ack");
  property p_ack_pulse;
    pready |=> !pready;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  property p_map_err;
    pready |-> pslverr == (paddr != 12'h084 && paddr != 12'h0D0);
  endproperty
  a_map_err: assert property (p_map_err) else $error("bad slverr");
  property p_cause_rsvd;
    pready && !pwrite && paddr == 12'h0D0 |-> prdata[31:4] == 28'h0;
  endproperty
  a_cause_rsvd: assert property (p_cause_rsvd) else $error("rsvd");
  property p_lvl2_en;
    rd_ctrl && safety_level_fuse && $past(safety_level_fuse, 4) |-> prdata[3];
  endproperty
  a_lvl2_en: assert property (p_lvl2_en) else $error("lvl2 en");
  property p_unlock_close;
    rd_ctrl && gap_q > 4'h6 |-> !prdata[4];
  endproperty
  a_unlock_close: assert property (p_unlock_close) else $error("open");
  property p_irq_gie;
    !cpu_gie |=> !wdog_irq;
  endproperty
  a_irq_gie: assert property (p_irq_gie) else $error("irq no gie");
  property p_rst_pulse;
    $rose(wdog_reset) |=> $fell(wdog_reset);
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("rst len");
endmodule
bind wdtc_top wdtc_properties u_props (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cpu_gie(cpu_gie),
  .safety_level_fuse(safety_level_fuse), .wdog_irq(wdog_irq),
  .wdog_reset(wdog_reset));
`default_nettype wire

/* verif/wdtc_tb_top.sv */
// Purpose: Self-checking bench for the watchdog control block
// Assumes: DIV_CYCLES set to 2, so one timeout at select 0 is 4096 cycles
// Notes:   Random select codes from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module wdtc_tb_top;
  localparam logic [11:0] CTRL  = 12'h084;
  localparam logic [11:0] CAUSE = 12'h0D0;
  localparam int          TO    = 4096;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        restart, gie, ack, fuse, pin, bo, irq, wrst;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  rd;
  logic [3:0]  s;
  int          n_errors, checks;
  wdtc_top #(.DIV_CYCLES(2)) u_dut (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdog_restart_instr(restart), .cpu_gie(gie), .irq_ack(ack),
    .safety_level_fuse(fuse), .pin_reset_req(pin), .brownout_req(bo),
    .wdog_irq(irq), .wdog_reset(wrst));
  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] enc(input logic [3:0] v, input logic e);
    return {2'b00, v[3], 1'b0, e, v[2:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk({24'h0, rd}, {24'h0, e});
  endtask
  task automatic wait_evt(input int exp, input int rs, input logic [1:0] ev);
    int n;
    n = 0;
    while (!(wrst || irq) && n < exp + 64) begin
      restart <= (n == rs);
      @(posedge mclk);
      n++;
    end
    chk(32'(n >= exp - 16 && n <= exp + 16), 32'h1);
    chk({30'h0, wrst, irq}, {30'h0, ev});
    if (n >= exp + 64)
      print_verdict();
  endtask
  task automatic pulse(input logic p);
    if (p)
      pin <= 1'b1;
    else
      bo <= 1'b1;
    repeat (4) @(posedge mclk);
    pin <= 1'b0;
    bo <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; restart = 0; gie = 0; ack = 0; fuse = 0; pin = 0; bo = 0;
    n_errors = 0;
    checks = 0;
    void'($urandom(32'h00AF8300));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rdchk(CAUSE, 8'h01);
    rdchk(CTRL, 8'h00);
    rdchk(12'h100, 8'h00);
    chk({31'h0, err}, 32'h1);
    pulse(1'b1);
    rdchk(CAUSE, 8'h03);
    pulse(1'b0);
    rdchk(CAUSE, 8'h07);
    apb(1'b1, CAUSE, 8'hFE);
    rdchk(CAUSE, 8'h06);
    apb(1'b1, CAUSE, 8'hF9);
    rdchk(CAUSE, 8'h00);
    $display("test cause done");
    apb(1'b1, CTRL, 8'h08);
    rdchk(CTRL, 8'h08);
    apb(1'b1, CTRL, 8'h00);
    rdchk(CTRL, 8'h08);
    apb(1'b1, CTRL, 8'h0F);
    rdchk(CTRL, 8'h08);
    repeat (4) begin
      s = 4'($urandom_range(9));
      apb(1'b1, CTRL, 8'h18);
      apb(1'b1, CTRL, enc(s, 1'b1));
      rdchk(CTRL, enc(s, 1'b1));
    end
    apb(1'b1, CTRL, 8'h18);
    repeat (8) @(posedge mclk);
    apb(1'b1, CTRL, 8'h00);
    rdchk(CTRL, enc(s, 1'b1));
    apb(1'b1, CTRL, 8'h18);
    apb(1'b1, CTRL, 8'h00);
    rdchk(CTRL, 8'h00);
    $display("test unlock done");
    apb(1'b1, CTRL, 8'h08);
    wait_evt(TO + 1000, 1000, 2'b10);
    rdchk(CAUSE, 8'h08);
    rdchk(CTRL, 8'h08);
    apb(1'b1, CTRL, 8'h18);
    apb(1'b1, CTRL, 8'h00);
    rdchk(CTRL, 8'h08);
    apb(1'b1, CAUSE, 8'h00);
    apb(1'b1, CTRL, 8'h18);
    apb(1'b1, CTRL, 8'h00);
    rdchk(CTRL, 8'h00);
    apb(1'b1, CTRL, 8'h18);
    apb(1'b1, CTRL, 8'h09);
    wait_evt(2 * TO, 0, 2'b10);
    apb(1'b1, CAUSE, 8'h00);
    $display("test reset mode done");
    apb(1'b1, CTRL, 8'h40);
    repeat (TO + 200) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rdchk(CTRL, 8'hC0);
    gie <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    ack <= 1'b1;
    @(posedge mclk);
    ack <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, CTRL, 8'h48);
    wait_evt(TO, 0, 2'b01);
    rdchk(CTRL, 8'h88);
    apb(1'b1, CTRL, 8'h88);
    rdchk(CTRL, 8'h08);
    wait_evt(TO, 0, 2'b10);
    $display("test irq mode done");
    fuse <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    rdchk(CTRL, 8'h08);
    apb(1'b1, CTRL, 8'h00);
    rdchk(CTRL, 8'h08);
    apb(1'b1, CTRL, 8'h18);
    apb(1'b1, CTRL, 8'h01);
    rdchk(CTRL, 8'h09);
    apb(1'b1, CTRL, 8'h02);
    rdchk(CTRL, 8'h09);
    wait_evt(2 * TO, 0, 2'b10);
    $display("test level 2 done");
    print_verdict();
  end
endmodule
`default_nettype wire
